// ---- bench/core_model.sv ----
// core-side model: live context, return stack depth, event and sleep lines
// assumes the bench commands events, sleep and return on plain level inputs
`timescale 1ns/1ns
`default_nettype none
module core_model
    import irq_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire irq_pkg::core_out_t ctl_i,
    input wire logic return_from_isr_instr_i,
    input wire logic sleep_i,
    input wire logic [2:0] ev_i,
    output irq_pkg::core_in_t core_o,
    output logic [3:0] depth_o
);
    ctx_t live;

    // status byte all ones so the masked bits show up in the shadow
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            live <= 64'h1716_1514_1312_ff10;
        end else if (ctl_i.restore_ctx) begin
            live <= ctl_i.shadow;
        end
    end

    // push and pop never land in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            depth_o <= 4'h0;
        end else if (ctl_i.push_pc) begin
            depth_o <= depth_o + 4'h1;
        end else if (ctl_i.pop_pc) begin
            depth_o <= depth_o - 4'h1;
        end
    end

    assign core_o = '{return_from_isr_instr: return_from_isr_instr_i, sleeping: sleep_i, tmr_ovf: ev_i[0],
        ext_edge: ev_i[1], ioc_any: ev_i[2], live: live};
endmodule : core_model
`default_nettype wire

// ---- bench/cpu_interrupt_controller_test.sv ----
// self-checking bench: wishbone register tasks plus core model stimulus
// assumes the controller answers each bus request with a one-cycle ack
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; \
    $display("unexpected at %0t: got %h, expected %h", $time, (a), (b)); end end
module cpu_interrupt_controller_test;
    import irq_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [ADR_W-1:0] adr = '0;
    logic [3:0] sel = 4'h0;
    logic [WB_W-1:0] wdat = '0;
    logic [WB_W-1:0] rdat;
    logic ack;
    core_in_t core_in;
    core_out_t core_out;
    logic [3:0][7:0] pev = '0;
    logic return_from_isr_instr = 1'b0;
    logic sleep = 1'b0;
    logic [2:0] ev = 3'h0;
    logic [3:0] depth;
    qphase_t qph;
    int n_errors = 0;
    int total_checks = 0;
    int n;

    always #2 clk_i = ~clk_i;

    cpu_interrupt_controller #(.N_PERIPH(4), .CLKS_PER_Q(1)) cpu_interrupt_controller_inst (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .core_i(core_in), .periph_event_i(pev), .core_o(core_out), .qphase_o(qph));

    core_model core_model_inst (.clk_i(clk_i), .rst_i(rst_i), .ctl_i(core_out),
        .return_from_isr_instr_i(return_from_isr_instr), .sleep_i(sleep), .ev_i(ev), .core_o(core_in), .depth_o(depth));

    task automatic print_verdict();
        if (n_errors == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict

    // entered right after a rising edge; leaves one idle cycle behind
    task automatic wb(input logic w, input logic [ADR_W-1:0] a, input logic [7:0] d,
                      output logic [7:0] q);
        int i;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'h1;
        wdat <= {24'h00_0000, d};
        for (i = 0; i < 20; i++) begin
            @(posedge clk_i);
            if (ack === 1'b1) break;
        end
        if (i == 20) begin
            n_errors++;
            print_verdict();
        end
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    task automatic wr(input logic [ADR_W-1:0] a, input logic [7:0] d);
        logic [7:0] q;
        wb(1'b1, a, d, q);
    endtask : wr

    task automatic rchk(input logic [ADR_W-1:0] a, input logic [7:0] e);
        logic [7:0] q;
        wb(1'b0, a, 8'h00, q);
        `CHK(q, e)
    endtask : rchk

    // n is lim + 1 when the strobe never showed
    task automatic wait_sig(input int which, input int lim, output int n);
        logic hit;
        for (n = 1; n <= lim; n++) begin
            @(posedge clk_i);
            case (which)
                0: hit = core_out.flush;
                1: hit = core_out.vector_load;
                2: hit = core_out.pop_pc;
                default: hit = core_out.wake;
            endcase
            if (hit === 1'b1) break;
        end
    endtask : wait_sig

    task automatic pulse(input logic [2:0] e);
        ev <= e;
        @(posedge clk_i);
        ev <= 3'h0;
    endtask : pulse

    task automatic leave_isr(input logic [7:0] ctl);
        int m;
        wr(OFF_PFLAG0, 8'h00);
        wr(OFF_CONTROL, ctl);
        return_from_isr_instr <= 1'b1;
        @(posedge clk_i);
        return_from_isr_instr <= 1'b0;
        wait_sig(2, 4, m);
        `CHK(m, 1)
    endtask : leave_isr

    initial begin
        repeat (50000) @(posedge clk_i);
        n_errors++;
        print_verdict();
    end

    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        `CHK(qph, Q1)
        rchk(OFF_CONTROL, 8'h00);
        rchk(OFF_PEN0, 8'h00);
        rchk(7'h44, 8'h00);
        `CHK(core_out.irq_req, 1'b0)
        // flags rise with every enable off
        pev[0] <= 8'h01;
        pulse(3'b001);
        pev[0] <= 8'h00;
        rchk(OFF_CONTROL, 8'h04);
        rchk(OFF_PFLAG0, 8'h01);
        wr(OFF_PEN0, 8'h01);
        wr(OFF_CONTROL, 8'h80);
        wait_sig(0, 12, n);
        `CHK(n, 13)
        wr(OFF_CONTROL, 8'hc0);
        wait_sig(0, 12, n);
        `CHK(n < 13, 1'b1)
        `CHK(core_out.shadow[CTX_STATUS], 8'he7)
        `CHK(core_out.shadow[CTX_W], 8'h10)
        wait_sig(1, 8, n);
        `CHK(n, 4)
        `CHK(core_out.vector_addr, VECTOR_ADDR)
        `CHK(depth, 4'h1)
        rchk(OFF_CONTROL, 8'h40);
        // a new event inside the handler only flags
        wr(OFF_CONTROL, 8'h50);
        pulse(3'b010);
        wait_sig(0, 12, n);
        `CHK(n, 13)
        rchk(OFF_CONTROL, 8'h52);
        wr(OFF_SHADOW0, 8'ha5);
        leave_isr(8'h40);
        @(posedge clk_i);
        `CHK(core_in.live[CTX_W], 8'ha5)
        `CHK(depth, 4'h0)
        rchk(OFF_CONTROL, 8'hc0);
        rchk(OFF_SHADOW0, 8'ha5);
        // entry latency: timer is synchronous, pin is not
        for (int s = 0; s < 2; s++) begin
            wr(OFF_CONTROL, s == 0 ? 8'ha0 : 8'h90);
            pulse(s == 0 ? 3'b001 : 3'b010);
            wait_sig(1, 24, n);
            if (s == 0) begin
                `CHK(n inside {[5:16]}, 1'b1)
            end else begin
                `CHK(n inside {[5:20]}, 1'b1)
            end
            leave_isr(s == 0 ? 8'h20 : 8'h10);
        end
        // sleep: timer cannot wake, pin can
        sleep <= 1'b1;
        wr(OFF_CONTROL, 8'h30);
        pulse(3'b001);
        repeat (4) @(posedge clk_i);
        `CHK(core_out.wake, 1'b0)
        pulse(3'b010);
        wait_sig(3, 8, n);
        `CHK(n < 9, 1'b1)
        sleep <= 1'b0;
        wait_sig(0, 12, n);
        `CHK(n, 13)
        sleep <= 1'b1;
        wr(OFF_CONTROL, 8'h90);
        pulse(3'b010);
        wait_sig(3, 8, n);
        sleep <= 1'b0;
        wait_sig(0, 16, n);
        `CHK(n inside {[5:13]}, 1'b1)
        leave_isr(8'h00);
        print_verdict();
    end
endmodule : cpu_interrupt_controller_test
`default_nettype wire

// ---- rtl/cpu_interrupt_controller.sv ----
// interrupt controller: flags, enables, entry sequencing, context shadows
// assumes a classic wishbone master and a core that obeys core_o strobes
// Notes on behaviour
// - any reset leaves every enable, the global one included, cleared
// - entry needs global enable, own enable, and group enable for peripherals
// - flags set on their event whatever the enables say
// - entry flushes, clears global enable, pushes pc, saves context, loads 0004h
// - with global enable clear an event only sets its flag; in sleep an enabled wake source also raises wake
// - return pops pc, restores shadows and sets global enable
// - a pending enabled flag is taken once global enable returns
// - synchronous sources reach the vector in three or four cycles
// - asynchronous sources reach the vector in three to five cycles
// - entry latency ignores whether the current instruction is long
// - external pin flag sampled for requests once per cycle at q1
// - external pin flag may become set only during q4 or q1
// - only sources running without system clock can wake from sleep
// - after wake, vector if global enable set, else carry on
// - after wake the instruction after sleep runs before the vector
// - saved context is w, status less timeout and power-down, bank, fsr, pc latch
// - shadows are bus readable and writable and are what return restores
//
// Our own choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module cpu_interrupt_controller #(
    parameter int N_PERIPH = 4,
    parameter int CLKS_PER_Q = 1,
    parameter logic [3:0][7:0] WAKE_CAPABLE = 32'h0000_0000
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [irq_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [irq_pkg::WB_W-1:0] wb_dat_i,
    output logic [irq_pkg::WB_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire irq_pkg::core_in_t core_i,
    input wire logic [N_PERIPH-1:0][irq_pkg::DATA_W-1:0] periph_event_i,
    output irq_pkg::core_out_t core_o,
    output irq_pkg::qphase_t qphase_o
);
    import irq_pkg::*;

    localparam int ICYC = Q_PER_CYCLE * CLKS_PER_Q;

    if (N_PERIPH < 1 || N_PERIPH > MAX_PERIPH) begin : g_chk
        $error("cpu_interrupt_controller: N_PERIPH out of range");
    end

    function automatic logic hit(input logic [ADR_W-1:0] adr, input logic [ADR_W-1:0] base,
                                 input int idx);
        hit = (adr == base + ADR_W'(idx * OFF_STEP));
    endfunction : hit

    logic q1_start;
    logic global_irq_enable, peripheral_group_enable, en_tmr, en_ext, en_ioc, flag_tmr, flag_ext;
    logic ext_pending, ext_window, ext_set, ext_sampled;
    logic [N_PERIPH-1:0][DATA_W-1:0] pflag;
    logic [N_PERIPH-1:0][DATA_W-1:0] pen;
    ctx_t shadow;
    entry_state_t state;
    logic wake_hold;
    logic core_act, periph_act, pend, irq_req, fire, wake, periph_wake;
    logic bus_wr, ctl_wr;
    logic [DATA_W-1:0] wd;
    logic [DATA_W-1:0] next_rd;
    // one driver per core strobe; the struct output is assembled in one place
    logic flush, push_pc, save_ctx, vector_load, pop_pc, restore_ctx;

    qphase_gen #(
        .CLKS_PER_Q(CLKS_PER_Q)
    ) u_qphase (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .qphase_o(qphase_o),
        .q1_start_o(q1_start)
    );

    // bus slave: ack one cycle after the strobe, write lands on the ack edge
    assign bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
    assign ctl_wr = bus_wr && hit(wb_adr_i, OFF_CONTROL, 0);
    assign wd = wb_dat_i[DATA_W-1:0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
        end
    end

    always_comb begin
        next_rd = RESET_BYTE;
        if (hit(wb_adr_i, OFF_CONTROL, 0)) begin
            next_rd = {global_irq_enable, peripheral_group_enable, en_tmr, en_ext, en_ioc, flag_tmr, flag_ext, core_i.ioc_any};
        end
        for (int k = 0; k < N_PERIPH; k++) begin
            if (hit(wb_adr_i, OFF_PFLAG0, k)) begin
                next_rd = pflag[k];
            end
            if (hit(wb_adr_i, OFF_PEN0, k)) begin
                next_rd = pen[k];
            end
        end
        for (int k = 0; k < CTX_BYTES; k++) begin
            if (hit(wb_adr_i, OFF_SHADOW0, k)) begin
                next_rd = shadow[k];
            end
        end
    end

    // unmapped words read as zero; upper bits always zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= '0;
        end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
            wb_dat_o <= {{(WB_W-DATA_W){1'b0}}, next_rd};
        end
    end

    // global enable: entry clear beats return set beats software
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            global_irq_enable <= 1'b0;
        end else if (fire) begin
            global_irq_enable <= 1'b0;
        end else if (core_i.return_from_isr_instr) begin
            global_irq_enable <= 1'b1;
        end else if (ctl_wr) begin
            global_irq_enable <= wd[BIT_GIE];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            peripheral_group_enable <= 1'b0;
            en_tmr <= 1'b0;
            en_ext <= 1'b0;
            en_ioc <= 1'b0;
        end else if (ctl_wr) begin
            peripheral_group_enable <= wd[BIT_PERIPHERAL_GROUP_ENABLE];
            en_tmr <= wd[BIT_TMR_EN];
            en_ext <= wd[BIT_EXT_EN];
            en_ioc <= wd[BIT_IOC_EN];
        end
    end

    // flags: an event in the clearing cycle still sets the flag
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_tmr <= 1'b0;
            flag_ext <= 1'b0;
        end else begin
            flag_tmr <= core_i.tmr_ovf || (ctl_wr ? wd[BIT_TMR_FLAG] : flag_tmr);
            flag_ext <= ext_set || (ctl_wr ? wd[BIT_EXT_FLAG] : flag_ext);
        end
    end

    // pin edges outside q4-q1 wait for the next window
    assign ext_window = (qphase_o == Q4) || (qphase_o == Q1);
    assign ext_set = (ext_pending || core_i.ext_edge) && ext_window;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_pending <= 1'b0;
        end else begin
            ext_pending <= (ext_pending || core_i.ext_edge) && !ext_window;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_sampled <= 1'b0;
        end else if (q1_start) begin
            ext_sampled <= flag_ext;
        end else begin
            // a cleared flag must not leave a stale copy that re-enters after return
            ext_sampled <= ext_sampled && flag_ext;
        end
    end

    for (genvar k = 0; k < N_PERIPH; k++) begin : g_periph
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                pflag[k] <= RESET_BYTE;
                pen[k] <= RESET_BYTE;
            end else begin
                pflag[k] <= periph_event_i[k] |
                    ((bus_wr && hit(wb_adr_i, OFF_PFLAG0, k)) ? wd : pflag[k]);
                if (bus_wr && hit(wb_adr_i, OFF_PEN0, k)) begin
                    pen[k] <= wd;
                end
            end
        end
    end

    // request tree
    always_comb begin
        periph_act = 1'b0;
        periph_wake = 1'b0;
        for (int k = 0; k < N_PERIPH; k++) begin
            periph_act = periph_act || |(pflag[k] & pen[k]);
            periph_wake = periph_wake || |(pflag[k] & pen[k] & WAKE_CAPABLE[k]);
        end
    end

    assign core_act = (en_tmr && flag_tmr) || (en_ext && ext_sampled) || (en_ioc && core_i.ioc_any);
    assign pend = core_act || (peripheral_group_enable && periph_act);
    assign irq_req = global_irq_enable && pend;
    // only taken at a cycle start, so instruction length never matters
    assign fire = q1_start && (state == ST_IDLE) && irq_req && !wake_hold &&
                  !core_i.sleeping;
    // timer needs the system clock, so it never wakes the core
    assign wake = core_i.sleeping && ((en_ext && flag_ext) || (en_ioc && core_i.ioc_any) ||
                  (peripheral_group_enable && periph_wake));

    // first cycle start after waking is left to the instruction after sleep
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_hold <= 1'b0;
        end else if (wake) begin
            wake_hold <= 1'b1;
        end else if (q1_start && !core_i.sleeping) begin
            wake_hold <= 1'b0;
        end
    end

    // entry: flush cycle, then vector cycle, then code at the vector
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (fire) begin
                        state <= ST_FLUSH;
                    end
                end
                ST_FLUSH: begin
                    if (q1_start) begin
                        state <= ST_VECTOR;
                    end
                end
                ST_VECTOR: begin
                    if (q1_start) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // shadows: capture on entry wins over a bus write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shadow <= '0;
        end else begin
            for (int k = 0; k < CTX_BYTES; k++) begin
                if (fire) begin
                    shadow[k] <= core_i.live[k];
                end else if (bus_wr && hit(wb_adr_i, OFF_SHADOW0, k)) begin
                    shadow[k] <= wd;
                end
            end
            if (fire) begin
                shadow[CTX_STATUS] <= (core_i.live[CTX_STATUS] & STATUS_SAVE_MASK) |
                                      (shadow[CTX_STATUS] & ~STATUS_SAVE_MASK);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flush <= 1'b0;
            push_pc <= 1'b0;
            save_ctx <= 1'b0;
            vector_load <= 1'b0;
            pop_pc <= 1'b0;
            restore_ctx <= 1'b0;
        end else begin
            flush <= fire;
            push_pc <= fire;
            save_ctx <= fire;
            vector_load <= (state == ST_FLUSH) && q1_start;
            pop_pc <= core_i.return_from_isr_instr && !fire;
            restore_ctx <= core_i.return_from_isr_instr && !fire;
        end
    end

    assign core_o = '{irq_req: irq_req, flush: flush, push_pc: push_pc, save_ctx: save_ctx,
                      vector_load: vector_load, vector_addr: VECTOR_ADDR, pop_pc: pop_pc,
                      restore_ctx: restore_ctx, wake: wake, shadow: shadow};

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_reset_off: assert property (disable iff (1'b0) rst_i |=> !global_irq_enable && !core_o.irq_req)
        else $error("enables not cleared by reset");
    a_gated_entry: assert property (fire |-> global_irq_enable && (core_act || (peripheral_group_enable && periph_act)))
        else $error("entry without enabled source");
    a_flag_set: assert property (periph_event_i[0][0] |=> pflag[0][0])
        else $error("peripheral flag not set by event");
    a_entry_steps: assert property (core_o.flush |-> !global_irq_enable && core_o.push_pc && core_o.save_ctx)
        else $error("entry steps incomplete");
    a_no_entry_off: assert property (!global_irq_enable |=> !core_o.flush)
        else $error("entry with global enable clear");
    a_return_sets: assert property (core_i.return_from_isr_instr && !fire |=> global_irq_enable && core_o.restore_ctx)
        else $error("return did not restore");
    a_pending_taken: assert property (global_irq_enable && pend && state == ST_IDLE && !wake_hold &&
        !core_i.sleeping && !ctl_wr |-> ##[0:ICYC] core_o.flush || !global_irq_enable)
        else $error("pending request not taken");
    a_vector_timing: assert property (core_o.flush |-> ##[ICYC:ICYC] core_o.vector_load)
        else $error("vector not loaded one cycle after flush");
    a_ext_window: assert property ($rose(flag_ext) && !$past(ctl_wr) |->
        $past(qphase_o) == Q4 || $past(qphase_o) == Q1)
        else $error("pin flag set outside q4-q1");
    a_wake_step: assert property ($past(wake) && !wake && !core_i.sleeping |-> !fire)
        else $error("vector taken before post-sleep instruction");

    c_entry: cover property (core_o.flush ##[1:ICYC] core_o.vector_load);
    c_return: cover property (core_o.restore_ctx);
    c_wake: cover property (wake ##[1:ICYC] !core_i.sleeping);
endmodule : cpu_interrupt_controller
`default_nettype wire

// ---- rtl/irq_pkg.sv ----
// constants, types and register map of the interrupt controller
// assumes a core that runs one instruction cycle as four q phases
package irq_pkg;
    localparam int DATA_W = 8;
    localparam int WB_W = 32;
    localparam int ADR_W = 7;
    localparam int Q_PER_CYCLE = 4;
    localparam int CTX_BYTES = 8;
    localparam int MAX_PERIPH = 4;

    // byte offsets on the register bus
    localparam logic [ADR_W-1:0] OFF_CONTROL = 7'h00;
    localparam logic [ADR_W-1:0] OFF_PFLAG0 = 7'h04;
    localparam logic [ADR_W-1:0] OFF_PEN0 = 7'h14;
    localparam logic [ADR_W-1:0] OFF_SHADOW0 = 7'h24;
    localparam logic [ADR_W-1:0] OFF_STEP = 7'h04;

    // irq_control_reg fields
    localparam int BIT_GIE = 7;
    localparam int BIT_PERIPHERAL_GROUP_ENABLE = 6;
    localparam int BIT_TMR_EN = 5;
    localparam int BIT_EXT_EN = 4;
    localparam int BIT_IOC_EN = 3;
    localparam int BIT_TMR_FLAG = 2;
    localparam int BIT_EXT_FLAG = 1;
    localparam int BIT_IOC_FLAG = 0;

    // context byte order in ctx_t
    localparam int CTX_W = 0;
    localparam int CTX_STATUS = 1;
    // status bits saved; timeout and power-down stay out
    localparam logic [DATA_W-1:0] STATUS_SAVE_MASK = 8'he7;
    localparam logic [DATA_W-1:0] RESET_BYTE = 8'h00;
    localparam logic [15:0] VECTOR_ADDR = 16'h0004;

    typedef logic [CTX_BYTES-1:0][DATA_W-1:0] ctx_t;
    typedef enum logic [1:0] {Q1, Q2, Q3, Q4} qphase_t;
    typedef enum logic [1:0] {ST_IDLE, ST_FLUSH, ST_VECTOR} entry_state_t;

    typedef struct packed {
        logic return_from_isr_instr;
        logic sleeping;
        logic tmr_ovf;
        logic ext_edge;
        logic ioc_any;
        ctx_t live;
    } core_in_t;

    typedef struct packed {
        logic irq_req;
        logic flush;
        logic push_pc;
        logic save_ctx;
        logic vector_load;
        logic [15:0] vector_addr;
        logic pop_pc;
        logic restore_ctx;
        logic wake;
        ctx_t shadow;
    } core_out_t;
endpackage : irq_pkg

// ---- rtl/qphase_gen.sv ----
// q phase sequencer of the instruction cycle
// assumes clk_i is the system clock; CLKS_PER_Q clocks per q phase
`timescale 1ns/1ns
`default_nettype none
module qphase_gen #(
    parameter int CLKS_PER_Q = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    output irq_pkg::qphase_t qphase_o,
    output logic q1_start_o
);
    import irq_pkg::*;

    localparam int DIV_W = (CLKS_PER_Q > 1) ? $clog2(CLKS_PER_Q) : 1;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CLKS_PER_Q - 1);

    logic [DIV_W-1:0] div;
    logic q_tick;

    if (CLKS_PER_Q < 1) begin : g_chk
        $error("qphase_gen: CLKS_PER_Q must be at least 1");
    end

    assign q_tick = (div == DIV_LAST);
    // start of cycle: first clock of q1
    assign q1_start_o = (qphase_o == Q1) && (div == '0);

    always_ff @(posedge clk_i) begin
        if (rst_i || q_tick) begin
            div <= '0;
        end else begin
            div <= div + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            qphase_o <= Q1;
        end else if (q_tick) begin
            qphase_o <= qphase_t'(qphase_o + 2'd1);
        end
    end
endmodule : qphase_gen
`default_nettype wire
